// [core/ebu_ctrl.sv]
// external bus unit: area decode, strobes, wait states, idle cycles, bus release
// assumes synchronous inputs on ref_clk, APB register access, cpu holds req until done
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps
module ebu_ctrl (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// mode pins
	input wire logic [2:0] mode,
	input wire logic hw_standby,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu request
	input wire ebu_pkg::ebu_cpu_req_t cpu_req,
	output logic cpu_done,
	output logic [15:0] cpu_rdata,
	output logic cpu_bus_granted,
	// external pins
	output ebu_pkg::ebu_pins_t pins,
	input wire logic [15:0] data_in,
	input wire logic wait_req_n,
	input wire logic ext_master_request_n,
	output logic bus_ack_n,
	output logic byte_bus_mode
);
	ebu_pkg::ebu_state_vec_t s_reg;
	ebu_pkg::ebu_state_vec_t s_next;
	logic [19:0] idx;
	logic apb_hit;
	logic apb_wr;
	logic [7:0] reg_rd;
	logic [2:0] dec_area;
	logic [1:0] wfield;
	logic need_idle;
	logic mode_16m;
	logic mode_single;
	logic [7:0] width_rst;
	logic [7:0] brel_rst;
	logic ext_req;
	logic init;

	assign idx = paddr[21:2];
	assign apb_wr = psel && penable && pwrite;
	assign mode_16m = (mode == 3'h3) || (mode == 3'h4) || (mode == 3'h5);
	assign mode_single = (mode == 3'h6) || (mode == 3'h7);
	assign init = rst || hw_standby;
	assign ext_req = !ext_master_request_n && s_reg.brel[ebu_pkg::BREL_ENABLE];

	// area is the field just above the per-area offset
	always_comb begin
		if (mode_16m) begin
			dec_area = cpu_req.addr[ebu_pkg::AREA_LSB_16M +: 3];
		end else begin
			dec_area = {1'b0, cpu_req.addr[ebu_pkg::AREA_LSB_1M +: 2]} |
				{cpu_req.addr[ebu_pkg::AREA_LSB_1M + 2], 2'h0};
		end
	end

	always_comb begin
		if (dec_area[2]) begin
			wfield = s_reg.wait_h[{dec_area[1:0], 1'b0} +: 2];
		end else begin
			wfield = s_reg.wait_l[{dec_area[1:0], 1'b0} +: 2];
		end
	end

	// idle after a read, before a read to another area or before a write
	assign need_idle = s_reg.last_valid && s_reg.last_rd &&
		((!cpu_req.wr && dec_area != s_reg.last_area && s_reg.bctl[ebu_pkg::BCTL_IDLE_AREA]) ||
		(cpu_req.wr && s_reg.bctl[ebu_pkg::BCTL_IDLE_RW]));

	always_comb begin
		unique case (idx)
			ebu_pkg::IDX_BUS_RELEASE_CONTROL: reg_rd = s_reg.brel;
			ebu_pkg::IDX_ADDRESS_CONTROL: reg_rd = s_reg.adr;
			ebu_pkg::IDX_AREA_SELECT_CONTROL: reg_rd = s_reg.asel;
			ebu_pkg::IDX_AREA_WIDTH_CONTROL: reg_rd = s_reg.width;
			ebu_pkg::IDX_ACCESS_STATE_CONTROL: reg_rd = s_reg.astate;
			ebu_pkg::IDX_WAIT_CONTROL_HIGH: reg_rd = s_reg.wait_h;
			ebu_pkg::IDX_WAIT_CONTROL_LOW: reg_rd = s_reg.wait_l;
			ebu_pkg::IDX_BUS_CONTROL: reg_rd = s_reg.bctl;
			ebu_pkg::IDX_STATUS: reg_rd = {3'h0, s_reg.granted, s_reg.st != ebu_pkg::ST_IDLE,
				s_reg.area};
			default: reg_rd = 8'h00;
		endcase
		apb_hit = (idx >= ebu_pkg::IDX_BUS_RELEASE_CONTROL && idx <= ebu_pkg::IDX_STATUS) &&
			(idx == ebu_pkg::IDX_BUS_RELEASE_CONTROL || idx >= ebu_pkg::IDX_ADDRESS_CONTROL);
	end

	always_comb begin
		width_rst = (mode == 3'h2 || mode == 3'h4) ? ebu_pkg::RST_WIDTH_16BIT :
			ebu_pkg::RST_WIDTH_8BIT;
		brel_rst = (mode == 3'h3 || mode == 3'h4) ? ebu_pkg::RST_BUS_RELEASE_M34 :
			ebu_pkg::RST_BUS_RELEASE;
	end

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.prdata = {24'h0, reg_rd};
		// registers
		if (apb_wr && apb_hit) begin
			unique case (idx)
				ebu_pkg::IDX_BUS_RELEASE_CONTROL: s_next.brel = pwdata[7:0];
				ebu_pkg::IDX_ADDRESS_CONTROL: s_next.adr = pwdata[7:0];
				ebu_pkg::IDX_AREA_SELECT_CONTROL: s_next.asel = pwdata[7:0];
				ebu_pkg::IDX_AREA_WIDTH_CONTROL: s_next.width = pwdata[7:0];
				ebu_pkg::IDX_ACCESS_STATE_CONTROL: s_next.astate = pwdata[7:0];
				ebu_pkg::IDX_WAIT_CONTROL_HIGH: s_next.wait_h = pwdata[7:0];
				ebu_pkg::IDX_WAIT_CONTROL_LOW: s_next.wait_l = pwdata[7:0];
				ebu_pkg::IDX_BUS_CONTROL: s_next.bctl = pwdata[7:0];
				default: s_next.bctl = s_reg.bctl;
			endcase
		end
		unique case (s_reg.st)
			ebu_pkg::ST_IDLE: begin
				s_next.pins.area_select_n = 8'hFF;
				s_next.pins.addr_valid_strobe_n = 1'b1;
				s_next.pins.read_n = 1'b1;
				s_next.pins.upper_byte_write_n = 1'b1;
				s_next.pins.lower_byte_write_n = 1'b1;
				s_next.pins.doe = 16'h0000;
				if (ext_req && !s_reg.granted) begin
					s_next.granted = 1'b1;
				end else if (ext_master_request_n && s_reg.granted) begin
					s_next.granted = 1'b0;
				end else if (cpu_req.req && !s_reg.granted && !s_reg.done) begin
					s_next.area = dec_area;
					s_next.cur_wr = cpu_req.wr;
					s_next.pins.addr = cpu_req.addr;
					if (!cpu_req.ext) begin
						// on-chip: fixed state count, no width or wait applied
						s_next.cur_8bit = 1'b0;
						s_next.cur_long = 1'b0;
						s_next.wcnt = 2'h0;
					end else begin
						s_next.cur_8bit = s_reg.width[dec_area] && !mode_single;
						s_next.cur_long = s_reg.astate[dec_area];
						s_next.wcnt = s_reg.astate[dec_area] ? wfield : 2'h0;
					end
					s_next.last_valid = cpu_req.ext;
					s_next.last_area = dec_area;
					s_next.last_rd = !cpu_req.wr;
					s_next.st = (cpu_req.ext && need_idle) ? ebu_pkg::ST_GAP : ebu_pkg::ST_T1;
				end
			end
			ebu_pkg::ST_GAP: begin
				s_next.st = ebu_pkg::ST_T1;
			end
			ebu_pkg::ST_T1: begin
				if (cpu_req.ext) begin
					s_next.pins.area_select_n = ~(8'h01 << s_reg.area);
					s_next.pins.addr_valid_strobe_n = 1'b0;
					s_next.pins.read_n = s_reg.cur_wr;
					if (s_reg.cur_wr) begin
						s_next.pins.dout = s_reg.cur_8bit ?
							(cpu_req.be[1] ? cpu_req.wdata : {cpu_req.wdata[7:0], 8'h00}) :
							cpu_req.wdata;
						s_next.pins.doe = s_reg.cur_8bit ? 16'hFF00 : 16'hFFFF;
						s_next.pins.upper_byte_write_n = !(cpu_req.be[1] || s_reg.cur_8bit);
						s_next.pins.lower_byte_write_n = !(cpu_req.be[0] && !s_reg.cur_8bit);
					end
				end
				s_next.st = s_reg.cur_long ? ebu_pkg::ST_T2 : ebu_pkg::ST_T3;
			end
			ebu_pkg::ST_T2: begin
				if (s_reg.wcnt != 2'h0) begin
					s_next.st = ebu_pkg::ST_TW;
				end else if (!wait_req_n && cpu_req.ext) begin
					s_next.st = ebu_pkg::ST_TW;
				end else begin
					s_next.st = ebu_pkg::ST_T3;
				end
			end
			ebu_pkg::ST_TW: begin
				if (s_reg.wcnt != 2'h0) begin
					s_next.wcnt = s_reg.wcnt - 2'h1;
				end
				if (s_reg.wcnt <= 2'h1 && (wait_req_n || !cpu_req.ext)) begin
					s_next.st = ebu_pkg::ST_T3;
				end
			end
			ebu_pkg::ST_T3: begin
				// sample read data at the last state, 8-bit areas use the upper lane
				s_next.rdata = s_reg.cur_8bit ? {8'h00, data_in[15:8]} : data_in;
				s_next.done = 1'b1;
				s_next.pins.area_select_n = 8'hFF;
				s_next.pins.addr_valid_strobe_n = 1'b1;
				s_next.pins.read_n = 1'b1;
				s_next.pins.upper_byte_write_n = 1'b1;
				s_next.pins.lower_byte_write_n = 1'b1;
				s_next.st = ebu_pkg::ST_IDLE;
			end
			default: s_next.st = ebu_pkg::ST_IDLE;
		endcase
		// reset and hardware standby both initialise; software standby is not an input
		if (init) begin
			s_next = '0;
			s_next.st = ebu_pkg::ST_IDLE;
			s_next.brel = brel_rst;
			s_next.adr = ebu_pkg::RST_ADDRESS_CONTROL;
			s_next.asel = ebu_pkg::RST_AREA_SELECT;
			s_next.width = width_rst;
			s_next.astate = ebu_pkg::RST_ACCESS_STATE;
			s_next.wait_h = ebu_pkg::RST_WAIT;
			s_next.wait_l = ebu_pkg::RST_WAIT;
			s_next.bctl = ebu_pkg::RST_BUS_CONTROL;
			s_next.pins.area_select_n = 8'hFF;
			s_next.pins.addr_valid_strobe_n = 1'b1;
			s_next.pins.read_n = 1'b1;
			s_next.pins.upper_byte_write_n = 1'b1;
			s_next.pins.lower_byte_write_n = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = psel && penable;
	assign pslverr = psel && penable && !apb_hit;
	assign pins = s_reg.pins;
	assign cpu_done = s_reg.done;
	assign cpu_rdata = s_reg.rdata;
	assign cpu_bus_granted = !s_reg.granted;
	assign bus_ack_n = !s_reg.granted;
	assign byte_bus_mode = (s_reg.width == 8'hFF);

	AST_SELECT_ONEHOT: assert property (@(posedge ref_clk) disable iff (rst)
		$countones(~pins.area_select_n) <= 1) else $error("two area selects low");
	AST_SELECT_IDLE: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.st == ebu_pkg::ST_IDLE |-> pins.area_select_n == 8'hFF)
		else $error("area select low while idle");
	AST_STROBE_WITH_SELECT: assert property (@(posedge ref_clk) disable iff (rst)
		(pins.area_select_n != 8'hFF) |-> !pins.addr_valid_strobe_n)
		else $error("select without address strobe");
	AST_READ_ONLY_READS: assert property (@(posedge ref_clk) disable iff (rst)
		!pins.read_n |-> pins.upper_byte_write_n && pins.lower_byte_write_n)
		else $error("read and write strobes together");
	AST_LOW_LANE_16: assert property (@(posedge ref_clk) disable iff (rst)
		!pins.lower_byte_write_n |-> !s_reg.cur_8bit)
		else $error("low write on 8-bit area");
	AST_SHORT_NO_WAIT: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.st == ebu_pkg::ST_T1 && !s_reg.cur_long |=> s_reg.st == ebu_pkg::ST_T3)
		else $error("two-state access stretched");
	AST_WAIT_COUNT: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.st == ebu_pkg::ST_T2 && s_reg.wcnt == 2'h3 |=>
		s_reg.st == ebu_pkg::ST_TW [*3]) else $error("three waits not inserted");
	AST_ACK_RELEASED: assert property (@(posedge ref_clk) disable iff (rst)
		!bus_ack_n |-> s_reg.st == ebu_pkg::ST_IDLE && pins.doe == 16'h0000)
		else $error("ack while bus driven");
	// in byte bus mode, outside modes 6 and 7, an external write may only use the upper lane
	AST_BYTE_MODE: assert property (@(posedge ref_clk) disable iff (rst)
		byte_bus_mode && !mode_single && !pins.upper_byte_write_n |->
		pins.lower_byte_write_n && pins.doe[7:0] == 8'h00)
		else $error("lower lane used in byte bus mode");
	AST_RESET_VALUES: assert property (@(posedge ref_clk)
		$past(rst) |-> s_reg.astate == 8'hFF && s_reg.wait_h == 8'hFF && s_reg.wait_l == 8'hFF)
		else $error("reset values wrong");
	AST_IDLE_GAP: assert property (@(posedge ref_clk) disable iff (rst)
		s_reg.st == ebu_pkg::ST_GAP |-> pins.area_select_n == 8'hFF)
		else $error("select during idle cycle");

	COV_READ: cover property (@(posedge ref_clk) !pins.read_n);
	COV_WRITE16: cover property (@(posedge ref_clk) !pins.lower_byte_write_n);
	COV_GAP: cover property (@(posedge ref_clk) s_reg.st == ebu_pkg::ST_GAP);
	COV_RELEASE: cover property (@(posedge ref_clk) !bus_ack_n);
endmodule : ebu_ctrl

// [core/ebu_pkg.sv]
// package for the external bus unit: register map, reset values, state and carrier types
// assumes a 32-bit APB slave with byte addresses formed as index * 4
package ebu_pkg;
	// register indices (printed offsets are not word aligned)
	localparam logic [19:0] IDX_BUS_RELEASE_CONTROL = 20'hEE013;
	localparam logic [19:0] IDX_ADDRESS_CONTROL = 20'hEE01E;
	localparam logic [19:0] IDX_AREA_SELECT_CONTROL = 20'hEE01F;
	localparam logic [19:0] IDX_AREA_WIDTH_CONTROL = 20'hEE020;
	localparam logic [19:0] IDX_ACCESS_STATE_CONTROL = 20'hEE021;
	localparam logic [19:0] IDX_WAIT_CONTROL_HIGH = 20'hEE022;
	localparam logic [19:0] IDX_WAIT_CONTROL_LOW = 20'hEE023;
	localparam logic [19:0] IDX_BUS_CONTROL = 20'hEE024;
	localparam logic [19:0] IDX_STATUS = 20'hEE025;
	localparam int ADDR_W = 22;
	localparam logic [7:0] RST_BUS_RELEASE = 8'hFE;
	localparam logic [7:0] RST_BUS_RELEASE_M34 = 8'hEE;
	localparam logic [7:0] RST_ADDRESS_CONTROL = 8'hFF;
	localparam logic [7:0] RST_AREA_SELECT = 8'h0F;
	localparam logic [7:0] RST_WIDTH_8BIT = 8'hFF;
	localparam logic [7:0] RST_WIDTH_16BIT = 8'h00;
	localparam logic [7:0] RST_ACCESS_STATE = 8'hFF;
	localparam logic [7:0] RST_WAIT = 8'hFF;
	localparam logic [7:0] RST_BUS_CONTROL = 8'hC6;
	// area field position in the address for each space size
	localparam int AREA_LSB_1M = 17;
	localparam int AREA_LSB_16M = 21;
	// bus control bits steering idle insertion
	localparam int BCTL_IDLE_AREA = 7;
	localparam int BCTL_IDLE_RW = 6;
	// bus release control bit enabling external master
	localparam int BREL_ENABLE = 0;
	localparam logic [1:0] STATES_SHORT = 2'h2;
	localparam logic [1:0] STATES_LONG = 2'h3;
	localparam logic [1:0] STATES_ONCHIP = 2'h2;

	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_T1 = 6'h02,
		ST_T2 = 6'h04,
		ST_TW = 6'h08,
		ST_T3 = 6'h10,
		ST_GAP = 6'h20
	} ebu_state_t;

	typedef struct packed {
		logic req;
		logic wr;
		logic ext;
		logic [23:0] addr;
		logic [1:0] be;
		logic [15:0] wdata;
	} ebu_cpu_req_t;

	typedef struct packed {
		logic [7:0] area_select_n;
		logic addr_valid_strobe_n;
		logic read_n;
		logic upper_byte_write_n;
		logic lower_byte_write_n;
		logic [23:0] addr;
		logic [15:0] dout;
		logic [15:0] doe;
	} ebu_pins_t;

	typedef struct packed {
		ebu_state_t st;
		logic [7:0] brel;
		logic [7:0] adr;
		logic [7:0] asel;
		logic [7:0] width;
		logic [7:0] astate;
		logic [7:0] wait_h;
		logic [7:0] wait_l;
		logic [7:0] bctl;
		logic [2:0] area;
		logic last_valid;
		logic [2:0] last_area;
		logic last_rd;
		logic cur_wr;
		logic cur_8bit;
		logic cur_long;
		logic [1:0] wcnt;
		logic [1:0] icnt;
		logic done;
		logic [15:0] rdata;
		logic granted;
		logic [31:0] prdata;
		ebu_pins_t pins;
	} ebu_state_vec_t;
endpackage : ebu_pkg

// [dv/ebu_ctrl_tb_top.sv]
// self-checking bench for the external bus unit: APB registers, cpu cycles, bus release
// assumes ebu_mem_model on the pins; runs mode 1, mode 2, hardware standby, then mode 3
`timescale 1ns/1ps
module ebu_ctrl_tb_top;
	localparam logic [15:0] MEM8 = (16'h1234 * 16'h0008) ^ 16'hA55A;
	logic ref_clk = 1'b0;
	logic rst, hw_standby, psel, penable, pwrite, pready, pslverr, cpu_done, cpu_bus_granted;
	logic wait_req_n, ext_master_request_n, bus_ack_n, byte_bus_mode, want_bus, err;
	logic [2:0] mode, stb;
	logic [1:0] hold_waits;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [15:0] cpu_rdata, data_in, cd;
	logic [7:0] sel;
	ebu_pkg::ebu_cpu_req_t cpu_req;
	ebu_pkg::ebu_pins_t pins;
	int mismatches = 0;
	int n_tests = 0;
	int n;
	logic [19:0] r_idx [8] = '{ebu_pkg::IDX_BUS_RELEASE_CONTROL, ebu_pkg::IDX_ADDRESS_CONTROL,
		ebu_pkg::IDX_AREA_SELECT_CONTROL, ebu_pkg::IDX_AREA_WIDTH_CONTROL,
		ebu_pkg::IDX_ACCESS_STATE_CONTROL, ebu_pkg::IDX_WAIT_CONTROL_HIGH,
		ebu_pkg::IDX_WAIT_CONTROL_LOW, ebu_pkg::IDX_BUS_CONTROL};
	// reset value expected beside the value written and read back
	logic [7:0] r_rst [8] = '{8'hFE, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hC6};
	logic [7:0] r_wv [8] = '{8'hFF, 8'hFE, 8'hFF, 8'h0F, 8'hF0, 8'hE4, 8'h00, 8'h00};

	always #5 ref_clk = ~ref_clk;

	ebu_ctrl i_ebu_ctrl (.ref_clk(ref_clk), .rst(rst), .mode(mode), .hw_standby(hw_standby),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
		.cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .cpu_bus_granted(cpu_bus_granted),
		.pins(pins), .data_in(data_in), .wait_req_n(wait_req_n),
		.ext_master_request_n(ext_master_request_n), .bus_ack_n(bus_ack_n),
		.byte_bus_mode(byte_bus_mode));
	ebu_mem_model i_ebu_mem_model (.ref_clk(ref_clk), .pins(pins), .data_in(data_in),
		.wait_req_n(wait_req_n), .ext_master_request_n(ext_master_request_n),
		.hold_waits(hold_waits), .want_bus(want_bus));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : final_report

	task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_val

	task automatic chk_cnt(input string nm, input int e, input int g);
		n_tests++;
		if (g != e) begin
			mismatches++;
			$display("[ERR] %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_cnt

	// pready is sampled at the edge itself, so the wait never depends on a fixed latency
	task automatic apb(input logic wr, input logic [19:0] idx, input logic [7:0] wd);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {10'h000, idx, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		// no local limit: only the watchdog may end this wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask : apb

	// one cpu cycle; counts edges to done and records selects and strobes seen meanwhile
	task automatic cyc(input logic wr, input logic ext, input logic [2:0] a,
		input logic [1:0] be, input logic [15:0] wd, input int exp_n);
		// area sits in the 1M field and, inverted, in the 16M field so the decoders differ
		cpu_req <= '{req: 1'b1, wr: wr, ext: ext, addr: {~a, 1'b0, a, 17'h00010},
			be: be, wdata: wd};
		n = 0;
		sel = 8'hFF;
		stb = 3'b000;
		do begin
			@(posedge ref_clk);
			n++;
			if (pins.addr_valid_strobe_n === 1'b0) begin
				sel = sel & pins.area_select_n;
			end
			stb = stb | ~{pins.upper_byte_write_n, pins.lower_byte_write_n, pins.read_n};
		end while (cpu_done !== 1'b1 && n < 40);
		cd = cpu_rdata;
		cpu_req.req <= 1'b0;
		@(posedge ref_clk);
		// done is seen one edge after the edge that raises it
		chk_cnt("cycles", exp_n, n - 1);
	endtask : cyc

	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		final_report();
	end

	initial begin
		rst <= 1'b1;
		hw_standby <= 1'b0;
		mode <= 3'h1;
		{psel, penable, pwrite, paddr, pwdata} <= '0;
		cpu_req <= '0;
		hold_waits <= 2'h0;
		want_bus <= 1'b0;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		for (int r = 0; r < 8; r++) begin
			apb(1'b0, r_idx[r], 8'h00);
			chk_val("reset value", {24'h0, r_rst[r]}, rd);
			apb(1'b1, r_idx[r], r_wv[r]);
			apb(1'b0, r_idx[r], 8'h00);
			chk_val("read back", {24'h0, r_wv[r]}, rd);
		end
		apb(1'b0, 20'hEE000, 8'h00);
		chk_val("unmapped", 32'h1, {31'h0, err});
		chk_val("byte_bus_mode", 32'h0, {31'h0, byte_bus_mode});
		$display("test registers done");
		// areas 0-3 two-state 8-bit, 4-7 three-state 16-bit with 0..3 waits, no idle gaps
		for (int a = 0; a < 8; a++) begin
			cyc(1'b0, 1'b1, a[2:0], (a > 3) ? 2'b11 : 2'b10, 16'h0000, (a > 3) ? a : 3);
			chk_val("area_select_n", {24'h0, ~(8'h01 << a)}, {24'h0, sel});
			chk_val("strobes", 32'h1, {29'h0, stb});
			chk_val("rdata", (a > 3) ? {16'h0, MEM8} : {24'h0, MEM8[15:8]},
				(a > 3) ? {16'h0, cd} : {24'h0, cd[7:0]});
		end
		$display("test area sweep done");
		cyc(1'b1, 1'b1, 3'h4, 2'b11, 16'hBEEF, 4);
		chk_val("write strobes", 32'h6, {29'h0, stb});
		cyc(1'b1, 1'b1, 3'h5, 2'b01, 16'h1234, 5);
		chk_val("lower strobe only", 32'h2, {29'h0, stb});
		cyc(1'b0, 1'b1, 3'h4, 2'b11, 16'h0000, 4);
		chk_val("merged lanes", 32'hBE34, {16'h0, cd});
		$display("test writes done");
		apb(1'b1, ebu_pkg::IDX_BUS_CONTROL, 8'hC0);
		cyc(1'b0, 1'b1, 3'h4, 2'b11, 16'h0000, 4);
		cyc(1'b0, 1'b1, 3'h5, 2'b11, 16'h0000, 6);
		cyc(1'b1, 1'b1, 3'h5, 2'b11, 16'hBE34, 6);
		cyc(1'b0, 1'b1, 3'h5, 2'b11, 16'h0000, 5);
		apb(1'b1, ebu_pkg::IDX_BUS_CONTROL, 8'h00);
		$display("test idle cycles done");
		hold_waits <= 2'h3;
		// three pin waits on a zero-wait three-state area: 4 + 3 states
		cyc(1'b0, 1'b1, 3'h4, 2'b11, 16'h0000, 7);
		cyc(1'b0, 1'b1, 3'h0, 2'b10, 16'h0000, 3);
		hold_waits <= 2'h0;
		// on-chip cycle to a slow three-state area number stays short and off the pins
		cyc(1'b0, 1'b0, 3'h7, 2'b11, 16'h0000, 3);
		chk_val("on-chip selects", 32'hFF, {24'h0, sel});
		$display("test waits done");
		want_bus <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (bus_ack_n !== 1'b0 && n < 10);
		chk_val("bus_ack_n", 32'h0, {31'h0, bus_ack_n});
		chk_val("cpu_bus_granted", 32'h0, {31'h0, cpu_bus_granted});
		want_bus <= 1'b0;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (bus_ack_n !== 1'b1 && n < 10);
		chk_val("bus_ack_n released", 32'h1, {31'h0, bus_ack_n});
		$display("test bus release done");
		mode <= 3'h2;
		rst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, ebu_pkg::IDX_AREA_WIDTH_CONTROL, 8'h00);
		chk_val("width mode 2", 32'h0, rd);
		apb(1'b1, ebu_pkg::IDX_ACCESS_STATE_CONTROL, 8'h00);
		apb(1'b1, ebu_pkg::IDX_WAIT_CONTROL_HIGH, 8'h00);
		mode <= 3'h1;
		hw_standby <= 1'b1;
		repeat (2) @(posedge ref_clk);
		hw_standby <= 1'b0;
		@(posedge ref_clk);
		apb(1'b0, ebu_pkg::IDX_AREA_WIDTH_CONTROL, 8'h00);
		chk_val("width standby", 32'hFF, rd);
		apb(1'b0, ebu_pkg::IDX_ACCESS_STATE_CONTROL, 8'h00);
		chk_val("access state standby", 32'hFF, rd);
		apb(1'b0, ebu_pkg::IDX_WAIT_CONTROL_HIGH, 8'h00);
		chk_val("wait standby", 32'hFF, rd);
		chk_val("byte_bus_mode", 32'h1, {31'h0, byte_bus_mode});
		$display("test reset modes done");
		// byte bus mode after standby: three-state, three waits, upper lane only
		cyc(1'b1, 1'b1, 3'h2, 2'b11, 16'hA5C3, 7);
		chk_val("byte mode write strobes", 32'h4, {29'h0, stb});
		cyc(1'b0, 1'b1, 3'h2, 2'b11, 16'h0000, 7);
		chk_val("byte mode rdata", 32'hA5, {16'h0, cd});
		$display("test byte bus done");
		mode <= 3'h3;
		rst <= 1'b1;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		apb(1'b0, ebu_pkg::IDX_BUS_RELEASE_CONTROL, 8'h00);
		chk_val("release mode 3", 32'hEE, rd);
		// release is disabled by its reset value here, so the request is refused
		want_bus <= 1'b1;
		repeat (4) @(posedge ref_clk);
		chk_val("bus_ack_n refused", 32'h1, {31'h0, bus_ack_n});
		want_bus <= 1'b0;
		@(posedge ref_clk);
		cyc(1'b0, 1'b1, 3'h6, 2'b11, 16'h0000, 7);
		chk_val("16M area_select_n", 32'hFD, {24'h0, sel});
		chk_val("16M rdata", 32'hA5, {16'h0, cd});
		$display("test 16M decode done");
		final_report();
	end
endmodule : ebu_ctrl_tb_top

// [dv/ebu_mem_model.sv]
// partner model: external memory that can hold the wait pin, plus an external bus master
// assumes the controller's registered pins and the single clock ref_clk
`timescale 1ns/1ps
module ebu_mem_model (
	// clock
	input wire logic ref_clk,
	// controller pins
	input wire ebu_pkg::ebu_pins_t pins,
	output logic [15:0] data_in,
	output logic wait_req_n,
	output logic ext_master_request_n,
	// bench control
	input wire logic [1:0] hold_waits,
	input wire logic want_bus
);
	logic [15:0] mem [16];
	logic [15:0] last_q;
	logic [1:0] wcnt;
	wire logic [3:0] idx = pins.addr[4:1];
	initial begin
		for (int i = 0; i < 16; i++) begin
			mem[i] = (16'h1234 * i[15:0]) ^ 16'hA55A;
		end
		last_q = 16'h0000;
		wcnt = 2'h0;
	end
	// no pull on the data lines, so a released bus shows the inverse of the last value
	assign data_in = (pins.read_n === 1'b0) ? mem[idx] : ~last_q;
	// wait is held low for the first hold_waits cycles of each strobed access
	assign wait_req_n = !(pins.addr_valid_strobe_n === 1'b0 && wcnt < hold_waits);
	// the request stays low for as long as the master needs the bus
	assign ext_master_request_n = !want_bus;
	always @(posedge ref_clk) begin
		if (pins.read_n === 1'b0) begin
			last_q <= mem[idx];
		end
		if (pins.upper_byte_write_n === 1'b0) begin
			mem[idx][15:8] <= pins.dout[15:8];
		end
		if (pins.lower_byte_write_n === 1'b0) begin
			mem[idx][7:0] <= pins.dout[7:0];
		end
		wcnt <= (pins.addr_valid_strobe_n !== 1'b0) ? 2'h0 : (wcnt == 2'h3) ? wcnt : wcnt + 2'h1;
	end
endmodule : ebu_mem_model
